// file: rtl/ulpi_pkg.sv
// Shared constants and types for the ULPI phy and link ends
package ulpi_pkg;
	// Interface clock and the link's own system clock
	localparam int         ULPI_HZ          = 60_000_000;
	localparam int         SYS_HZ           = 40_000_000;
	// Command byte type field, bits 7:6
	localparam logic [1:0] CMD_SPECIAL      = 2'h0;
	localparam logic [1:0] CMD_TRANSMIT     = 2'h1;
	localparam logic [1:0] CMD_REG_WR       = 2'h2;
	localparam logic [1:0] CMD_REG_RD       = 2'h3;
	// Register addresses inside the phy
	localparam logic [5:0] ADDR_FUNC_CTRL   = 6'h04;
	localparam logic [5:0] ADDR_OTG_CTRL    = 6'h0a;
	// Field positions
	localparam int         FC_RESET_BIT     = 5;
	localparam int         FC_SUSPEND_N_BIT = 6;
	localparam int         OTG_PUMP_BIT     = 5;
	localparam int         OTG_EXT_BIT      = 6;
	localparam int         RXCMD_VBUS_POS   = 2;
	// Values after reset
	localparam logic [7:0] FC_RESET_VAL     = 8'h41;
	localparam logic [7:0] OTG_RESET_VAL    = 8'h00;
	// Vbus state code meaning no fault
	localparam logic [1:0] VBUS_GOOD        = 2'h3;
	// Kinds of request from the link's user
	typedef enum logic [1:0] {
		KIND_WRITE    = 2'h0,
		KIND_READ     = 2'h1,
		KIND_TRANSMIT = 2'h2
	} kind_t;
endpackage : ulpi_pkg

// file: rtl/ulpi_if.sv
// ULPI bus between the phy end and the link end
`timescale 1ns/1ps
`default_nettype none
interface ulpi_if;
	logic       ulpi_clk;
	logic [7:0] data_phy;
	logic       data_phy_oe;
	logic [7:0] data_link;
	logic       data_link_oe;
	logic       dir;
	logic       dir_oe;
	logic       nxt;
	logic       nxt_oe;
	logic       stp;
	logic       cs_n;
	logic [7:0] data;
	logic       dir_w;
	logic       nxt_w;
	// Resolved wire levels; weak pull-downs win when nobody drives
	assign data  = data_phy_oe ? data_phy : (data_link_oe ? data_link : 8'h00);
	assign dir_w = dir_oe & dir;
	assign nxt_w = nxt_oe & nxt;
	modport phy (input ulpi_clk, data, stp, cs_n,
		output data_phy, data_phy_oe, dir, dir_oe, nxt, nxt_oe);
	modport link (input ulpi_clk, data, dir_w, nxt_w,
		output data_link, data_link_oe, stp, cs_n);
endinterface : ulpi_if
`default_nettype wire

// file: rtl/sync2.sv
// Two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk_in,
	input  wire logic         resetn_in,
	// Level in, synchronised level out
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta_q;
	// First stage feeds only the second
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			meta_q <= '0;
			q_out  <= '0;
		end else begin
			meta_q <= d_in;
			q_out  <= meta_q;
		end
	end
endmodule : sync2
`default_nettype wire

// file: rtl/ulpi_phy_end.sv
// Phy end of the ULPI bus: direction, stop, next, data and supply controls
// Overview of operation
// - ext supply bit set drives switch low
// - link clears ext bit on bad vbus
// - internal drive bit enables charge pump
// - link enters low power before stopping oscillator
// - async active-low reset loads reset values, dir high
// - dir low by default, high to send
// - dir high during reset and low power
// - deselected: dir, nxt, data go undriven
// - deselected: stop input ignored
// - link stops each packet and write
// - stop while dir high drops dir next
// - nxt low default, high pulls link bytes
// - nxt high on each received data byte
// - nxt low for read data and status
// - clock output unless oscillator tied low
// - one turnaround cycle per dir change
// - link idles bus at zero, nonzero command
// - nxt marks data, else status or read
// - link issues reset command after power-up
`timescale 1ns/1ps
`default_nettype none
module ulpi_phy_end (
	// Bus toward the link, clocked by its interface clock
	ulpi_if.phy              bus,
	input  wire logic        resetn_in,
	// Straps and analog status
	input  wire logic        osc_tied_low_in,
	input  wire logic [1:0]  vbus_state_in,
	input  wire logic [1:0]  line_state_in,
	// Received USB stream from the analog front end
	input  wire logic        rx_active_in,
	input  wire logic        rx_valid_in,
	input  wire logic [7:0]  rx_byte_in,
	// Transmit stream toward the front end
	output logic [7:0]       tx_byte_out,
	output logic             tx_valid_out,
	output logic             tx_end_out,
	// Supply and clock controls
	output logic             ext_power_switch_low_out,
	output logic             ext_power_switch_low_oe_out,
	output logic             pump_enable_out,
	output logic             clock_drive_oe_out,
	output logic             low_power_out
);
	import ulpi_pkg::*;

	typedef enum logic [3:0] {
		ST_RESET = 4'h0,
		ST_IDLE  = 4'h1,
		ST_CMD   = 4'h3,
		ST_TX    = 4'h2,
		ST_WR    = 4'h6,
		ST_WSTP  = 4'h7,
		ST_TURN  = 4'h5,
		ST_SEND  = 4'h4,
		ST_RX    = 4'hc,
		ST_LPM   = 4'hd
	} phy_state_t;

	phy_state_t st_q, st_d;
	logic       dir_q, dir_d, nxt_q, nxt_d, doe_q, doe_d;
	logic       oe_q, oe_d, rxm_q, rxm_d, lpm_q, lpm_d;
	logic [7:0] dout_q, dout_d, cmd_q, cmd_d, wd_q, wd_d;
	logic [7:0] otg_q, otg_d, fc_q, fc_d, txb_q, txb_d;
	logic [3:0] rep_q, rep_d;
	logic       txv_q, txv_d, txe_q, txe_d;
	logic [3:0] stat_s;
	logic       stp_eff;
	logic [7:0] status;

	// Register file read decode
	function automatic logic [7:0] reg_value(input logic [5:0] a,
		input logic [7:0] fc, input logic [7:0] otg);
		reg_value = 8'h00;
		if (a == ADDR_FUNC_CTRL)
			reg_value = fc;
		else if (a == ADDR_OTG_CTRL)
			reg_value = otg;
	endfunction : reg_value

	// Analog status and clock strap enter through two flops
	sync2 #(.W(4)) stat_sync (
		.clk_in    (bus.ulpi_clk),
		.resetn_in (resetn_in),
		.d_in      ({vbus_state_in, line_state_in}),
		.q_out     (stat_s)
	);
	sync2 #(.W(1)) clk_sync (
		.clk_in    (bus.ulpi_clk),
		.resetn_in (resetn_in),
		.d_in      (~osc_tied_low_in),
		.q_out     (clock_drive_oe_out)
	);

	assign stp_eff = bus.stp & ~bus.cs_n;
	assign status  = {4'h0, stat_s};

	// Next-state logic of the bus sequencer
	always_comb begin
		st_d  = st_q;
		dir_d = dir_q;
		nxt_d = 1'b0;
		doe_d = 1'b0;
		dout_d = dout_q;
		cmd_d = cmd_q;
		wd_d  = wd_q;
		rxm_d = rxm_q;
		otg_d = otg_q;
		fc_d  = fc_q;
		rep_d = rep_q;
		txb_d = txb_q;
		txv_d = 1'b0;
		txe_d = 1'b0;
		fc_d[FC_RESET_BIT] = 1'b0;
		unique case (st_q)
			ST_RESET: begin
				dir_d = 1'b0;
				st_d  = ST_IDLE;
			end
			ST_IDLE: begin
				if (rx_active_in) begin
					dir_d = 1'b1;
					rxm_d = 1'b1;
					st_d  = ST_TURN;
				end else if (bus.data != 8'h00) begin
					cmd_d = bus.data;
					nxt_d = 1'b1;
					st_d  = ST_CMD;
				end else if (stat_s != rep_q) begin
					dir_d = 1'b1;
					rxm_d = 1'b0;
					cmd_d = 8'h00;
					st_d  = ST_TURN;
				end
			end
			ST_CMD: begin
				unique case (cmd_q[7:6])
					CMD_TRANSMIT: begin
						nxt_d = 1'b1;
						st_d  = ST_TX;
					end
					CMD_REG_WR: begin
						nxt_d = 1'b1;
						st_d  = ST_WR;
					end
					CMD_REG_RD: begin
						dir_d = 1'b1;
						rxm_d = 1'b0;
						st_d  = ST_TURN;
					end
					CMD_SPECIAL: st_d = ST_IDLE;
				endcase
			end
			ST_TX: begin
				if (stp_eff) begin
					txe_d = 1'b1;
					st_d  = ST_IDLE;
				end else begin
					nxt_d = 1'b1;
					txv_d = 1'b1;
					txb_d = bus.data;
				end
			end
			ST_WR: begin
				wd_d = bus.data;
				st_d = ST_WSTP;
			end
			ST_WSTP: begin
				if (stp_eff) begin
					st_d = ST_IDLE;
					if (cmd_q[5:0] == ADDR_OTG_CTRL)
						otg_d = wd_q;
					if (cmd_q[5:0] == ADDR_FUNC_CTRL) begin
						fc_d = wd_q;
						if (wd_q[FC_RESET_BIT])
							otg_d = OTG_RESET_VAL;
						if (!wd_q[FC_SUSPEND_N_BIT]) begin
							dir_d = 1'b1;
							st_d  = ST_LPM;
						end
					end
				end
			end
			ST_TURN: begin
				// Turnaround over, start driving the bus
				doe_d = 1'b1;
				if (rxm_q) begin
					st_d   = ST_RX;
					nxt_d  = rx_valid_in;
					dout_d = rx_valid_in ? rx_byte_in : status;
				end else begin
					st_d = ST_SEND;
					if (cmd_q[7:6] == CMD_REG_RD) begin
						dout_d = reg_value(cmd_q[5:0], fc_q, otg_q);
					end else begin
						dout_d = status;
						rep_d  = stat_s;
					end
				end
			end
			ST_SEND: begin
				dir_d = 1'b0;
				st_d  = ST_IDLE;
			end
			ST_RX: begin
				if (!rx_active_in) begin
					dir_d = 1'b0;
					st_d  = ST_IDLE;
				end else begin
					doe_d  = 1'b1;
					nxt_d  = rx_valid_in;
					dout_d = rx_valid_in ? rx_byte_in : status;
				end
			end
			ST_LPM: begin
				if (stp_eff) begin
					dir_d = 1'b0;
					fc_d[FC_SUSPEND_N_BIT] = 1'b1;
					st_d  = ST_IDLE;
				end
			end
			default: begin
				dir_d = 1'b1;
				st_d  = ST_RESET;
			end
		endcase
		// Link stop while the phy owns the bus ends the transfer
		if (dir_q && stp_eff && (st_q == ST_TURN || st_q == ST_SEND || st_q == ST_RX)) begin
			dir_d = 1'b0;
			nxt_d = 1'b0;
			doe_d = 1'b0;
			st_d  = ST_IDLE;
		end
		oe_d  = ~bus.cs_n;
		doe_d = doe_d & ~bus.cs_n;
		lpm_d = (st_d == ST_LPM);
	end

	// Registers of the sequencer, all on the rising interface edge
	always_ff @(posedge bus.ulpi_clk or negedge resetn_in) begin
		if (!resetn_in) begin
			st_q   <= ST_RESET;
			dir_q  <= 1'b1;
			nxt_q  <= 1'b0;
			doe_q  <= 1'b0;
			oe_q   <= 1'b0;
			dout_q <= 8'h00;
			cmd_q  <= 8'h00;
			wd_q   <= 8'h00;
			rxm_q  <= 1'b0;
			otg_q  <= OTG_RESET_VAL;
			fc_q   <= FC_RESET_VAL;
			rep_q  <= 4'h0;
			txb_q  <= 8'h00;
			txv_q  <= 1'b0;
			txe_q  <= 1'b0;
			lpm_q  <= 1'b0;
		end else begin
			st_q   <= st_d;
			dir_q  <= dir_d;
			nxt_q  <= nxt_d;
			doe_q  <= doe_d;
			oe_q   <= oe_d;
			dout_q <= dout_d;
			cmd_q  <= cmd_d;
			wd_q   <= wd_d;
			rxm_q  <= rxm_d;
			otg_q  <= otg_d;
			fc_q   <= fc_d;
			rep_q  <= rep_d;
			txb_q  <= txb_d;
			txv_q  <= txv_d;
			txe_q  <= txe_d;
			lpm_q  <= lpm_d;
		end
	end

	// Pin and user outputs straight from flops
	assign bus.dir         = dir_q;
	assign bus.dir_oe      = oe_q;
	assign bus.nxt         = nxt_q;
	assign bus.nxt_oe      = oe_q;
	assign bus.data_phy    = dout_q;
	assign bus.data_phy_oe = doe_q;
	assign tx_byte_out     = txb_q;
	assign tx_valid_out    = txv_q;
	assign tx_end_out      = txe_q;
	assign low_power_out   = lpm_q;
	// Open-drain switch: pulled low while enabled
	assign ext_power_switch_low_out    = 1'b0;
	assign ext_power_switch_low_oe_out = otg_q[OTG_EXT_BIT];
	assign pump_enable_out             = otg_q[OTG_PUMP_BIT];
endmodule : ulpi_phy_end
`default_nettype wire

// file: rtl/ulpi_link_end.sv
// Link end of the ULPI bus: register access, transmit, supply and suspend control
`timescale 1ns/1ps
`default_nettype none
module ulpi_link_end (
	// System clock and reset
	input  wire logic           clock_in,
	input  wire logic           resetn_in,
	// Bus toward the phy
	ulpi_if.link                bus,
	// Requests from the user
	input  wire logic           req_in,
	input  wire ulpi_pkg::kind_t kind_in,
	input  wire logic [5:0]     addr_in,
	input  wire logic [7:0]     wdata_in,
	output logic                busy_out,
	output logic                done_out,
	output logic [7:0]          rdata_out,
	// Suspend, abort and supply status
	input  wire logic           suspend_in,
	input  wire logic           abort_in,
	output logic                osc_stop_ok_out,
	output logic                overcurrent_out
);
	import ulpi_pkg::*;

	typedef enum logic [2:0] {
		L_IDLE = 3'h0,
		L_CMD  = 3'h1,
		L_DATA = 3'h3,
		L_STP  = 3'h2,
		L_RD   = 3'h6,
		L_LPM  = 3'h4
	} link_state_t;
	typedef enum logic [1:0] {J_USER, J_RESET, J_OC, J_SUSP} job_t;

	// System domain
	logic       rtg_q, rtg_d, busy_q, busy_d, done_q, done_d, aseen_q, aseen_d;
	logic [7:0] rdat_q, rdat_d, hcmd_q, hcmd_d, hdat_q, hdat_d;
	logic       ack_s;
	// Link domain
	link_state_t st_q, st_d;
	job_t       job_q, job_d;
	logic [7:0] jc_q, jc_d, jd_q, jd_d, out_q, out_d, rd_q, rd_d, otg_q, otg_d;
	logic       oe_q, oe_d, stp_q, stp_d, dp_q, dp_d, csn_q;
	logic       atg_q, atg_d, rseen_q, rseen_d, rst_q, rst_d, ocp_q, ocp_d;
	logic       oc_q, oc_d, sus_q, sus_d, ok_q, ok_d;
	logic [2:0] lnk_s;

	// Request toggle and levels into the link domain
	sync2 #(.W(3)) in_sync (
		.clk_in    (bus.ulpi_clk),
		.resetn_in (resetn_in),
		.d_in      ({rtg_q, suspend_in, abort_in}),
		.q_out     (lnk_s)
	);
	// Acknowledge toggle and status levels back to the system domain
	sync2 #(.W(3)) out_sync (
		.clk_in    (clock_in),
		.resetn_in (resetn_in),
		.d_in      ({atg_q, ok_q, oc_q}),
		.q_out     ({ack_s, osc_stop_ok_out, overcurrent_out})
	);

	// System side: hold request words until acknowledged
	always_comb begin
		rtg_d   = rtg_q;
		busy_d  = busy_q;
		done_d  = 1'b0;
		aseen_d = ack_s;
		rdat_d  = rdat_q;
		hcmd_d  = hcmd_q;
		hdat_d  = hdat_q;
		if (ack_s != aseen_q) begin
			busy_d = 1'b0;
			done_d = 1'b1;
			rdat_d = rd_q;
		end else if (req_in && !busy_q) begin
			busy_d = 1'b1;
			rtg_d  = ~rtg_q;
			hdat_d = wdata_in;
			unique case (kind_in)
				KIND_WRITE:    hcmd_d = {CMD_REG_WR, addr_in};
				KIND_READ:     hcmd_d = {CMD_REG_RD, addr_in};
				KIND_TRANSMIT: hcmd_d = {CMD_TRANSMIT, addr_in};
				default:       hcmd_d = {CMD_REG_RD, addr_in};
			endcase
		end
	end

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rtg_q   <= 1'b0;
			busy_q  <= 1'b0;
			done_q  <= 1'b0;
			aseen_q <= 1'b0;
			rdat_q  <= 8'h00;
			hcmd_q  <= 8'h00;
			hdat_q  <= 8'h00;
		end else begin
			rtg_q   <= rtg_d;
			busy_q  <= busy_d;
			done_q  <= done_d;
			aseen_q <= aseen_d;
			rdat_q  <= rdat_d;
			hcmd_q  <= hcmd_d;
			hdat_q  <= hdat_d;
		end
	end

	// Link side sequencer
	always_comb begin
		st_d = st_q;
		job_d = job_q;
		jc_d = jc_q;
		jd_d = jd_q;
		out_d = 8'h00;
		rd_d = rd_q;
		otg_d = otg_q;
		stp_d = 1'b0;
		dp_d = bus.dir_w;
		atg_d = atg_q;
		rseen_d = rseen_q;
		rst_d = rst_q;
		ocp_d = ocp_q;
		oc_d = oc_q;
		sus_d = sus_q;
		// Status byte from the phy: check vbus; low power and stop cycles carry none
		if (bus.dir_w && dp_q && !bus.nxt_w && st_q != L_RD && st_q != L_LPM
			&& !stp_q) begin
			oc_d = (bus.data[RXCMD_VBUS_POS +: 2] != VBUS_GOOD);
			if (oc_d && otg_q[OTG_EXT_BIT])
				ocp_d = 1'b1;
		end
		unique case (st_q)
			L_IDLE: begin
				if (bus.dir_w) begin
					stp_d = lnk_s[0] & ~stp_q;
				end else if (!dp_q) begin
					st_d = L_CMD;
					if (rst_q) begin
						job_d = J_RESET;
						jc_d  = {CMD_REG_WR, ADDR_FUNC_CTRL};
						jd_d  = FC_RESET_VAL | 8'h20;
					end else if (ocp_q) begin
						job_d = J_OC;
						jc_d  = {CMD_REG_WR, ADDR_OTG_CTRL};
						jd_d  = otg_q & ~8'h40;
					end else if (lnk_s[1] && !sus_q) begin
						job_d = J_SUSP;
						jc_d  = {CMD_REG_WR, ADDR_FUNC_CTRL};
						jd_d  = FC_RESET_VAL & ~8'h40;
					end else if (lnk_s[2] != rseen_q) begin
						job_d = J_USER;
						jc_d  = hcmd_q;
						jd_d  = hdat_q;
					end else begin
						st_d = L_IDLE;
					end
					if (st_d == L_CMD)
						out_d = jc_d;
				end
			end
			L_CMD: begin
				out_d = jc_q;
				if (bus.dir_w) begin
					st_d  = L_IDLE;
					out_d = 8'h00;
				end else if (bus.nxt_w) begin
					st_d  = (jc_q[7:6] == CMD_REG_RD) ? L_RD : L_DATA;
					out_d = (jc_q[7:6] == CMD_REG_RD) ? 8'h00 : jd_q;
				end
			end
			L_DATA: begin
				out_d = jd_q;
				if (bus.nxt_w) begin
					out_d = 8'h00;
					stp_d = 1'b1;
					st_d  = L_STP;
				end
			end
			L_STP, L_RD: begin
				if (st_q == L_STP || (bus.dir_w && dp_q)) begin
					st_d = L_IDLE;
					if (st_q == L_RD)
						rd_d = bus.data;
					unique case (job_q)
						J_RESET: begin
							rst_d = 1'b0;
							otg_d = OTG_RESET_VAL;
						end
						J_OC: begin
							ocp_d = 1'b0;
							otg_d = jd_q;
						end
						J_SUSP: begin
							sus_d = 1'b1;
							st_d  = L_LPM;
						end
						J_USER: begin
							rseen_d = lnk_s[2];
							atg_d   = ~atg_q;
							if (jc_q == {CMD_REG_WR, ADDR_OTG_CTRL})
								otg_d = jd_q;
						end
					endcase
				end
			end
			L_LPM: begin
				if (!lnk_s[1] && bus.dir_w) begin
					stp_d = 1'b1;
					sus_d = 1'b0;
					st_d  = L_IDLE;
				end
			end
			default: st_d = L_IDLE;
		endcase
		oe_d = ~bus.dir_w;
		ok_d = sus_d & bus.dir_w & (st_d == L_LPM);
	end

	// Link side registers, all on the rising interface edge
	always_ff @(posedge bus.ulpi_clk or negedge resetn_in) begin
		if (!resetn_in) begin
			st_q    <= L_IDLE;
			job_q   <= J_USER;
			jc_q    <= 8'h00;
			jd_q    <= 8'h00;
			out_q   <= 8'h00;
			rd_q    <= 8'h00;
			otg_q   <= OTG_RESET_VAL;
			oe_q    <= 1'b0;
			stp_q   <= 1'b1;
			dp_q    <= 1'b1;
			csn_q   <= 1'b1;
			atg_q   <= 1'b0;
			rseen_q <= 1'b0;
			rst_q   <= 1'b1;
			ocp_q   <= 1'b0;
			oc_q    <= 1'b0;
			sus_q   <= 1'b0;
			ok_q    <= 1'b0;
		end else begin
			st_q    <= st_d;
			job_q   <= job_d;
			jc_q    <= jc_d;
			jd_q    <= jd_d;
			out_q   <= out_d;
			rd_q    <= rd_d;
			otg_q   <= otg_d;
			oe_q    <= oe_d;
			stp_q   <= stp_d;
			dp_q    <= dp_d;
			csn_q   <= 1'b0;
			atg_q   <= atg_d;
			rseen_q <= rseen_d;
			rst_q   <= rst_d;
			ocp_q   <= ocp_d;
			oc_q    <= oc_d;
			sus_q   <= sus_d;
			ok_q    <= ok_d;
		end
	end

	// Outputs straight from flops
	assign bus.data_link    = out_q;
	assign bus.data_link_oe = oe_q;
	assign bus.stp          = stp_q;
	assign bus.cs_n         = csn_q;
	assign busy_out         = busy_q;
	assign done_out         = done_q;
	assign rdata_out        = rdat_q;
endmodule : ulpi_link_end
`default_nettype wire

// file: tb/ulpi_wire_checker.sv
// Concurrent checks on the ULPI wires between the phy and link ends
`timescale 1ns/1ps
`default_nettype none
module ulpi_wire_checker (
	// Interface clock and phy reset
	input  wire logic       ulpi_clk,
	input  wire logic       resetn_in,
	// Bus signals
	input  wire logic [7:0] data,
	input  wire logic       data_phy_oe,
	input  wire logic       data_link_oe,
	input  wire logic       dir,
	input  wire logic       dir_oe,
	input  wire logic       dir_w,
	input  wire logic       nxt_oe,
	input  wire logic       nxt_w,
	input  wire logic       stp,
	input  wire logic       cs_n
);
	logic [1:0] cmd_type;

	// Command type field of the byte on the bus
	assign cmd_type = data[7:6];

	default clocking cb @(posedge ulpi_clk);
	endclocking
	default disable iff (!resetn_in);

	// Bus ownership and turnaround
	a_dir_after_reset: assert property (!$past(resetn_in) |-> dir)
		else $error("dir not high leaving reset");
	a_drive_needs_dir: assert property (data_phy_oe |-> dir_w && $past(dir_w))
		else $error("phy drives data without owning the bus");
	a_turnaround_phy: assert property ($changed(dir_w) |-> !data_phy_oe)
		else $error("phy drives data in turnaround");
	a_turnaround_link: assert property ($past(dir_w) && dir_w |-> !data_link_oe)
		else $error("link drives data while phy owns bus");
	a_deselect_float: assert property (cs_n |=> !dir_oe && !nxt_oe && !data_phy_oe)
		else $error("outputs driven while deselected");
	a_abort_drops_dir: assert property (dir_w && stp && !cs_n |=> !dir_w)
		else $error("dir not dropped after stop");
	// Next signalling
	a_nxt_after_cmd: assert property ($rose(nxt_w) && !dir_w |-> $past(data) != 8'h00)
		else $error("nxt raised without a link byte");
	a_read_no_nxt: assert property ($rose(dir_w) && $past(nxt_w) && !$past(nxt_w, 2)
		&& $past(cmd_type, 2) == 2'h3
		|-> !nxt_w ##1 (data_phy_oe && !nxt_w) ##1 !dir_w)
		else $error("read data framing wrong");
	a_rx_nxt_drives: assert property (nxt_w && dir_w |-> data_phy_oe)
		else $error("nxt high with no byte driven");
endmodule : ulpi_wire_checker
`default_nettype wire

// file: tb/ulpi_phy_pin_control_tb.sv
// Self-checking bench for the phy and link ends joined by the ULPI bus
`timescale 1ns/1ps
`default_nettype none
module ulpi_phy_pin_control_tb;
	import ulpi_pkg::*;
	logic       clock_in, phy_resetn, link_resetn, uclk_run, osc_tied, rx_active, rx_valid;
	logic       req, busy, done, suspend, abort, osc_ok, overcurrent;
	logic       tx_valid, tx_end, psw, psw_oe, pump, clk_oe, low_power;
	logic [1:0] vbus, line;
	logic [5:0] addr;
	logic [7:0] rx_byte, wdata, rdata, tx_byte;
	kind_t      kind;
	int         n_mismatch, num_checks;
	ulpi_if ulpi_if_i ();
	ulpi_phy_end ulpi_phy_end_i (.bus(ulpi_if_i.phy), .resetn_in(phy_resetn),
		.osc_tied_low_in(osc_tied), .vbus_state_in(vbus), .line_state_in(line),
		.rx_active_in(rx_active), .rx_valid_in(rx_valid), .rx_byte_in(rx_byte),
		.tx_byte_out(tx_byte), .tx_valid_out(tx_valid), .tx_end_out(tx_end),
		.ext_power_switch_low_out(psw), .ext_power_switch_low_oe_out(psw_oe),
		.pump_enable_out(pump), .clock_drive_oe_out(clk_oe), .low_power_out(low_power));
	ulpi_link_end ulpi_link_end_i (.clock_in(clock_in), .resetn_in(link_resetn),
		.bus(ulpi_if_i.link), .req_in(req), .kind_in(kind), .addr_in(addr), .wdata_in(wdata),
		.busy_out(busy), .done_out(done), .rdata_out(rdata), .suspend_in(suspend),
		.abort_in(abort), .osc_stop_ok_out(osc_ok), .overcurrent_out(overcurrent));
	ulpi_wire_checker ulpi_wire_checker_i (.ulpi_clk(ulpi_if_i.ulpi_clk),
		.resetn_in(phy_resetn), .data(ulpi_if_i.data), .data_phy_oe(ulpi_if_i.data_phy_oe),
		.data_link_oe(ulpi_if_i.data_link_oe), .dir(ulpi_if_i.dir), .dir_oe(ulpi_if_i.dir_oe),
		.dir_w(ulpi_if_i.dir_w), .nxt_oe(ulpi_if_i.nxt_oe), .nxt_w(ulpi_if_i.nxt_w),
		.stp(ulpi_if_i.stp), .cs_n(ulpi_if_i.cs_n));

	// System clock and gated interface clock
	initial begin
		clock_in = 1'b0;
		forever #12.5 clock_in = ~clock_in;
	end
	initial begin
		uclk_run = 1'b1;
		ulpi_if_i.ulpi_clk = 1'b0;
		forever begin
			#3;
			if (uclk_run) ulpi_if_i.ulpi_clk = ~ulpi_if_i.ulpi_clk;
		end
	end

	task automatic close_out;
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : close_out

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
			n_mismatch++;
		end
	endtask : chk

	task automatic user_req(input kind_t k, input logic [5:0] a, input logic [7:0] d);
		int i;
		for (i = 0; i < 400 && busy !== 1'b0; i++) @(negedge clock_in);
		@(posedge clock_in);
		req <= 1'b1;
		kind <= k;
		addr <= a;
		wdata <= d;
		@(posedge clock_in);
		req <= 1'b0;
		for (i = 0; i < 400 && done !== 1'b1; i++) @(negedge clock_in);
		chk({6'h00, busy, done}, 8'h01);
	endtask : user_req

	// Supply bits reach the switch and pump pins, read back over the bus
	task automatic s_supply;
		user_req(KIND_WRITE, ADDR_OTG_CTRL, 8'h60);
		chk({5'h00, psw_oe, psw, pump}, 8'h05);
		user_req(KIND_READ, ADDR_OTG_CTRL, 8'h00);
		chk(rdata, 8'h01 << OTG_EXT_BIT | 8'h01 << OTG_PUMP_BIT);
		user_req(KIND_WRITE, ADDR_OTG_CTRL, OTG_RESET_VAL);
		chk({6'h00, psw_oe, pump}, 8'h00);
	endtask : s_supply

	// Received bytes with nxt, then status bytes without
	task automatic s_rx;
		int i;
		int seen;
		seen = 0;
		@(posedge ulpi_if_i.ulpi_clk);
		rx_byte <= 8'h5a;
		rx_valid <= 1'b1;
		rx_active <= 1'b1;
		for (i = 0; i < 12; i++) begin
			@(negedge ulpi_if_i.ulpi_clk);
			if (ulpi_if_i.nxt_w === 1'b1) seen++;
			if (ulpi_if_i.nxt_w === 1'b1) chk(ulpi_if_i.data, 8'h5a);
		end
		chk({7'h00, seen != 0}, 8'h01);
		@(posedge ulpi_if_i.ulpi_clk);
		rx_valid <= 1'b0;
		// Last data byte still stands for one cycle
		@(posedge ulpi_if_i.ulpi_clk);
		for (i = 0; i < 6; i++) begin
			@(negedge ulpi_if_i.ulpi_clk);
			if (ulpi_if_i.data_phy_oe === 1'b1) chk(ulpi_if_i.data, {4'h0, VBUS_GOOD, 2'h1});
		end
		@(posedge ulpi_if_i.ulpi_clk);
		rx_active <= 1'b0;
		repeat (3) @(negedge ulpi_if_i.ulpi_clk);
		chk({7'h00, ulpi_if_i.dir_w}, 8'h00);
	endtask : s_rx

	// Link abort while the phy owns the bus
	task automatic s_abort;
		int i;
		@(posedge ulpi_if_i.ulpi_clk);
		rx_valid <= 1'b1;
		rx_active <= 1'b1;
		repeat (4) @(posedge ulpi_if_i.ulpi_clk);
		abort <= 1'b1;
		for (i = 0; i < 40 && ulpi_if_i.dir_w !== 1'b0; i++) @(negedge ulpi_if_i.ulpi_clk);
		chk({7'h00, ulpi_if_i.dir_w}, 8'h00);
		@(posedge ulpi_if_i.ulpi_clk);
		abort <= 1'b0;
		rx_active <= 1'b0;
		rx_valid <= 1'b0;
		repeat (8) @(posedge ulpi_if_i.ulpi_clk);
	endtask : s_abort

	// Transmit packet ends with stop and reaches the front end
	task automatic s_transmit;
		int i;
		fork
			user_req(KIND_TRANSMIT, 6'h01, 8'ha5);
			begin
				for (i = 0; i < 2000 && tx_valid !== 1'b1; i++) @(negedge ulpi_if_i.ulpi_clk);
				chk(tx_byte, 8'ha5);
				for (i = 0; i < 20 && tx_end !== 1'b1; i++) @(negedge ulpi_if_i.ulpi_clk);
				chk({7'h00, tx_end}, 8'h01);
			end
		join
	endtask : s_transmit

	// Bad vbus makes the link switch the external supply off
	task automatic s_overcurrent;
		int i;
		user_req(KIND_WRITE, ADDR_OTG_CTRL, 8'h01 << OTG_EXT_BIT);
		chk({7'h00, psw_oe}, 8'h01);
		@(posedge ulpi_if_i.ulpi_clk);
		vbus <= 2'h1;
		for (i = 0; i < 400 && psw_oe !== 1'b0; i++) @(negedge clock_in);
		chk({6'h00, overcurrent, psw_oe}, 8'h02);
		@(posedge ulpi_if_i.ulpi_clk);
		vbus <= VBUS_GOOD;
		repeat (20) @(posedge clock_in);
		chk({7'h00, overcurrent}, 8'h00);
	endtask : s_overcurrent

	// Suspend, stop the interface clock, restart, then resume
	task automatic s_low_power;
		int i;
		@(posedge clock_in);
		suspend <= 1'b1;
		for (i = 0; i < 1000 && osc_ok !== 1'b1; i++) @(negedge clock_in);
		chk({4'h0, overcurrent, osc_ok, low_power, ulpi_if_i.dir_w}, 8'h07);
		@(posedge ulpi_if_i.ulpi_clk);
		uclk_run = 1'b0;
		repeat (20) @(posedge clock_in);
		uclk_run = 1'b1;
		repeat (4) @(posedge ulpi_if_i.ulpi_clk);
		@(posedge clock_in);
		suspend <= 1'b0;
		for (i = 0; i < 1000 && low_power !== 1'b0; i++) @(negedge clock_in);
		chk({5'h00, overcurrent, low_power, ulpi_if_i.dir_w}, 8'h00);
	endtask : s_low_power

	// Deselect, link reset command, phy reset mid-run and the clock strap
	task automatic s_pins;
		user_req(KIND_WRITE, ADDR_OTG_CTRL, 8'h01 << OTG_PUMP_BIT);
		@(posedge clock_in);
		link_resetn <= 1'b0;
		repeat (4) @(negedge ulpi_if_i.ulpi_clk);
		chk({5'h00, ulpi_if_i.dir_oe, ulpi_if_i.nxt_oe, ulpi_if_i.data_phy_oe}, 8'h00);
		repeat (2) @(posedge clock_in);
		link_resetn <= 1'b1;
		// Reset command from the link clears the pump bit
		user_req(KIND_READ, ADDR_OTG_CTRL, 8'h00);
		chk(rdata, OTG_RESET_VAL);
		chk({7'h00, pump}, 8'h00);
		user_req(KIND_WRITE, ADDR_OTG_CTRL, 8'h01 << OTG_PUMP_BIT);
		@(posedge clock_in);
		phy_resetn <= 1'b0;
		repeat (3) @(negedge ulpi_if_i.ulpi_clk);
		chk({5'h00, ulpi_if_i.dir, pump, psw_oe}, 8'h04);
		repeat (2) @(posedge clock_in);
		phy_resetn <= 1'b1;
		repeat (4) @(negedge ulpi_if_i.ulpi_clk);
		chk({7'h00, clk_oe}, 8'h01);
		@(posedge ulpi_if_i.ulpi_clk);
		osc_tied <= 1'b1;
		repeat (6) @(negedge ulpi_if_i.ulpi_clk);
		chk({7'h00, clk_oe}, 8'h00);
		@(posedge ulpi_if_i.ulpi_clk);
		osc_tied <= 1'b0;
	endtask : s_pins

	// Watchdog against a hang
	initial begin
		#400_000;
		n_mismatch++;
		close_out();
	end

	// Main sequence
	initial begin
		n_mismatch = 0;
		num_checks = 0;
		{phy_resetn, link_resetn, osc_tied, rx_active, rx_valid, req, suspend, abort} = 8'h00;
		{vbus, line, addr, rx_byte, wdata} = {VBUS_GOOD, 2'h1, 6'h00, 16'h0000};
		kind = KIND_WRITE;
		repeat (2) @(posedge clock_in);
		phy_resetn <= 1'b1;
		link_resetn <= 1'b1;
		s_supply();
		s_rx();
		s_abort();
		s_transmit();
		s_overcurrent();
		s_low_power();
		s_pins();
		close_out();
	end
endmodule : ulpi_phy_pin_control_tb
`default_nettype wire
